//--- tb/reference_ladder_control_bench.sv
// Purpose: Self-checking bench for the reference ladder control register
// Assumes: AXI4-Lite master driven by bench tasks, one access at a time
// Notes: Inputs change on the rising edge; handshakes are judged at the falling edge

`timescale 1ns/1ps

// ==========================================================
// Bench top
module reference_ladder_control_bench;
	logic aclk;
	logic aresetn;
	logic [15:0] awaddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic [1:0] bresp, rresp;
	logic [15:0] araddr;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] rdata;
	logic en, oe, rng, src, pin;
	logic [3:0] tap;
	logic [6:0] lvl;
	int n_mismatch;
	int comparisons;
	int b_hold; // Cycles of late bready, so a held response is exercised

	// Design under test
	reference_ladder_control u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ref_enable(en), .ref_pin_output_enable(oe),
		.ref_range_select(rng), .ref_source_select(src), .ref_tap_code(tap),
		.ref_output_pin_connect(pin), .ref_level_96ths(lvl));

	// 50 ns clock
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// ==========================================================
	// Reporting
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// ==========================================================
	// Bus tasks; the loop bound stands in for a hung slave
	task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] exp_resp);
		int n;
		logic fa, fw, fb, done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (b_hold == 0);
		for (n = 0; n < 40 && !done; n++)
		begin
			@(negedge aclk);
			fa = awvalid && (awready === 1'b1);
			fw = wvalid && (wready === 1'b1);
			fb = (bvalid === 1'b1) && bready;
			if (fb)
				check("bresp", {30'h0, exp_resp}, {30'h0, bresp});
			@(posedge aclk);
			if (fa)
				awvalid <= 1'b0;
			if (fw)
				wvalid <= 1'b0;
			if (fb)
			begin
				bready <= 1'b0;
				done = 1'b1;
			end
			else if (n + 1 >= b_hold)
				bready <= 1'b1;
		end
		if (!done)
		begin
			n_mismatch++;
			print_verdict();
		end
	endtask : axi_write

	task automatic read_check(input logic [15:0] a, input logic [31:0] exp,
		input logic [1:0] exp_resp);
		int n;
		logic fa, done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40 && !done; n++)
		begin
			@(negedge aclk);
			fa = arvalid && (arready === 1'b1);
			if (rvalid === 1'b1)
			begin
				check("rdata", exp, rdata);
				check("rresp", {30'h0, exp_resp}, {30'h0, rresp});
				done = 1'b1;
			end
			@(posedge aclk);
			if (fa)
				arvalid <= 1'b0;
			if (done)
				rready <= 1'b0;
		end
		if (!done)
		begin
			n_mismatch++;
			print_verdict();
		end
	endtask : read_check

	// Ladder outputs against a control word, level worked out by hand
	task automatic check_out(input logic [31:0] c);
		logic [6:0] e;
		@(negedge aclk);
		e = !c[15] ? 7'h00 : c[5] ? {1'b0, c[3:0], 2'b00} : 7'h18 + 7'(c[3:0]) * 7'h03;
		check("fields", {24'h0, c[15], c[6:0]}, {24'h0, en, oe, rng, src, tap});
		check("level", {25'h0, e}, {25'h0, lvl});
		check("pin", {31'h0, c[15] & c[6]}, {31'h0, pin});
	endtask : check_out

	// ==========================================================
	// Scenarios
	task automatic sc_reset_and_mask();
		read_check(16'h9800, 32'h0000_0000, 2'h0);
		check_out(32'h0);
		axi_write(16'h9800, 32'hffff_ffff, 4'hf, 2'h0);
		read_check(16'h9800, 32'h0000_807f, 2'h0);
		check_out(32'h807f);
	endtask : sc_reset_and_mask

	task automatic sc_enable_keeps();
		axi_write(16'h9804, 32'h0000_8000, 4'hf, 2'h0);
		repeat (2) @(posedge aclk); // quiet gap after clearing enable
		read_check(16'h9800, 32'h0000_007f, 2'h0);
		check_out(32'h007f);
		axi_write(16'h9808, 32'h0000_8000, 4'hf, 2'h0);
		read_check(16'h9800, 32'h0000_807f, 2'h0);
	endtask : sc_enable_keeps

	task automatic sc_aliases();
		axi_write(16'h9800, 32'h0000_8025, 4'hf, 2'h0);
		axi_write(16'h9808, 32'h0000_0040, 4'hf, 2'h0);
		read_check(16'h9808, 32'h0000_8065, 2'h0);
		axi_write(16'h9804, 32'h0000_0005, 4'hf, 2'h0);
		read_check(16'h9804, 32'h0000_8060, 2'h0);
		axi_write(16'h980c, 32'hffff_0013, 4'hf, 2'h0);
		read_check(16'h980c, 32'h0000_8073, 2'h0);
		check_out(32'h8073);
	endtask : sc_aliases

	task automatic sc_unmapped_and_strobe();
		b_hold = 2;
		axi_write(16'h9810, 32'h0000_0000, 4'hf, 2'h3); // Late bready: response must stand
		b_hold = 0;
		read_check(16'h9810, 32'h0000_0000, 2'h3);
		read_check(16'h9800, 32'h0000_8073, 2'h0);
		axi_write(16'h9800, 32'h0000_0000, 4'h1, 2'h0);
		read_check(16'h9800, 32'h0000_8000, 2'h0);
	endtask : sc_unmapped_and_strobe

	// Every tap in both ranges, source bit alternating
	task automatic sc_levels();
		logic [31:0] c;
		for (int r = 0; r < 2; r++)
		begin
			for (int t = 0; t < 16; t++)
			begin
				c = 32'h8000 | (32'(r) << 5) | (32'(t & 1) << 4) | 32'(t) | 32'h40;
				axi_write(16'h9800, c, 4'hf, 2'h0);
				check_out(c);
			end
		end
	endtask : sc_levels

	// ==========================================================
	// Main sequence
	initial
	begin
		n_mismatch = 0;
		comparisons = 0;
		b_hold = 0;
		aresetn = 1'b0;
		awaddr = 16'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 16'h0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		sc_reset_and_mask();
		sc_enable_keeps();
		sc_aliases();
		sc_unmapped_and_strobe();
		sc_levels();
		print_verdict();
	end
endmodule : reference_ladder_control_bench

//--- verilog/ladder_level_calc.sv
// Purpose: Tap level and pin connection from the control fields
// Assumes: Fields come from flops on the same clock
// Notes: Outputs lag the control register by one cycle

`timescale 1ns/1ps

// ==========================================================
// Level calculator
module ladder_level_calc
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control fields
	input wire logic enable,
	input wire logic pin_oe,
	input wire logic range_hi,
	input wire logic [3:0] tap,
	// Results
	output logic [6:0] level_96ths,
	output logic pin_connect
);

	logic [6:0] level_r;
	logic [6:0] level_nxt;
	logic pin_r;
	logic pin_nxt;

	// Step of 1/24 is 4/96; offset range is 24/96 plus 3/96 per step
	always_comb
	begin
		level_nxt = 7'h00;
		if (enable)
		begin
			if (range_hi)
				level_nxt = 7'(tap) * ref_ladder_pkg::LVL_HIGH_STEP;
			else
				level_nxt = ref_ladder_pkg::LVL_LOW_BASE
					+ 7'(tap) * ref_ladder_pkg::LVL_LOW_STEP;
		end
		pin_nxt = enable & pin_oe;
	end

	// Disabled ladder draws no current, so the level reads as zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			level_r <= 7'h00;
			pin_r <= 1'b0;
		end
		else
		begin
			level_r <= level_nxt;
			pin_r <= pin_nxt;
		end
	end

	assign level_96ths = level_r;
	assign pin_connect = pin_r;

	// ==========================================================
	// Assertions
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Fields held for a cycle, so the registered level has caught up
	sequence s_hi_stable;
		enable && range_hi ##1 $stable(enable) && $stable(range_hi) && $stable(tap);
	endsequence

	sequence s_lo_stable;
		enable && !range_hi ##1 $stable(enable) && $stable(range_hi) && $stable(tap);
	endsequence

	chk_pin_connect: assert property (
		pin_connect == ($past(enable) && $past(pin_oe)))
		else $error("pin connection does not follow enable and pin output");

	chk_level_high: assert property (
		s_hi_stable |-> level_96ths == {1'b0, tap, 2'b00})
		else $error("high range level wrong");

	chk_level_low: assert property (
		s_lo_stable |-> level_96ths == 7'(tap) * 7'h03 + 7'h18)
		else $error("offset range level wrong");

	chk_level_off: assert property (
		!enable ##1 !enable |-> level_96ths == 7'h00)
		else $error("level present while disabled");

endmodule : ladder_level_calc

//--- verilog/ref_ladder_pkg.sv
// Purpose: Shared constants for the reference ladder control block
// Assumes: 32-bit AXI4-Lite register access, byte addresses
// Notes: Level is expressed in 1/96 units of the source span

// ==========================================================
// Package
package ref_ladder_pkg;

	// ==========================================================
	// Register map
	localparam logic [15:0] CTRL_OFFSET = 16'h9800;
	localparam logic [15:0] CLR_ALIAS_OFS = 16'h0004;
	localparam logic [15:0] SET_ALIAS_OFS = 16'h0008;
	localparam logic [15:0] INV_ALIAS_OFS = 16'h000c;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_IMPL_MASK = 32'h0000_807f;

	// ==========================================================
	// Field positions
	localparam int EN_BIT = 15;
	localparam int OE_BIT = 6;
	localparam int RANGE_BIT = 5;
	localparam int SRC_BIT = 4;
	localparam int TAP_LSB = 0;
	localparam int TAP_W = 4;

	// ==========================================================
	// Level arithmetic, in 1/96 of the span
	localparam int LVL_W = 7;
	localparam logic [6:0] LVL_HIGH_STEP = 7'h04;
	localparam logic [6:0] LVL_LOW_STEP = 7'h03;
	localparam logic [6:0] LVL_LOW_BASE = 7'h18;

	// ==========================================================
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Access kinds, coded as address bits 3:2
	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_CLR = 2'b01,
		OP_SET = 2'b10,
		OP_INV = 2'b11
	} alias_op_e;

endpackage : ref_ladder_pkg

//--- verilog/reference_ladder_control.sv
// Purpose: AXI4-Lite control register for a 16-tap reference ladder
// Assumes: One write and one read outstanding at most
// Notes: Reads of any alias return the control register
//
// Function
// - Bit 15 enables the module; clear disables it with no current drawn.
// - Changing the enable bit leaves all other control fields unchanged.
// - Bit 6 connects the level to the output pin when set together with bit 15.
// - Bit 5 picks range: 0..0.625 in 1/24 steps, or 0.25..0.71875 in 1/32.
// - Bit 4 picks supply: external reference pair or analog rails.
// - High range: level equals tap code over 24 times the span.
// - Offset range: level equals quarter span plus tap over 32 times span.
// - Bits 31-16 and 14-7 read zero and ignore writes.
// - Clear, set and invert aliases sit at base plus 0x4, 0x8, 0xC.

`timescale 1ns/1ps

// ==========================================================
// Top
module reference_ladder_control
#(
	parameter int ADDR_W = 16
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// Write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// Read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Ladder controls
	output logic ref_enable,
	output logic ref_pin_output_enable,
	output logic ref_range_select,
	output logic ref_source_select,
	output logic [3:0] ref_tap_code,
	output logic ref_output_pin_connect,
	output logic [6:0] ref_level_96ths
);

	// ==========================================================
	// Elaboration check
	if (ADDR_W < 16)
	begin : g_bad_addr_w
		$error("ADDR_W must be at least 16");
	end

	// ==========================================================
	// Functions
	// Decode an address into {hit, access kind}
	function automatic logic [2:0] decode_addr(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] base;
		base = ADDR_W'(ref_ladder_pkg::CTRL_OFFSET);
		decode_addr = {(a[ADDR_W-1:4] == base[ADDR_W-1:4]), a[3:2]};
	endfunction : decode_addr

	// Expand byte strobes into a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : strb_mask

	// Plain write replaces strobed lanes, zeros too; aliases touch only ones in m
	function automatic logic [31:0] apply_op(input logic [1:0] op,
		input logic [31:0] cur, input logic [31:0] m, input logic [3:0] s);
		logic [31:0] r;
		r = cur;
		case (op)
			ref_ladder_pkg::OP_WRITE: r = (cur & ~strb_mask(s)) | m;
			ref_ladder_pkg::OP_CLR: r = cur & ~m;
			ref_ladder_pkg::OP_SET: r = cur | m;
			ref_ladder_pkg::OP_INV: r = cur ^ m;
			default: r = cur;
		endcase
		apply_op = r & ref_ladder_pkg::CTRL_IMPL_MASK;
	endfunction : apply_op

	// ==========================================================
	// Control register
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;

	// ==========================================================
	// Write channel
	typedef enum logic [0:0] {
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} wr_state_e;

	wr_state_e wr_state_r;
	wr_state_e wr_state_nxt;
	logic aw_have_r;
	logic aw_have_nxt;
	logic w_have_r;
	logic w_have_nxt;
	logic [ADDR_W-1:0] awaddr_r;
	logic [ADDR_W-1:0] awaddr_nxt;
	logic [31:0] wdata_r;
	logic [31:0] wdata_nxt;
	logic [3:0] wstrb_r;
	logic [3:0] wstrb_nxt;
	logic [1:0] bresp_r;
	logic [1:0] bresp_nxt;
	logic aw_hit;
	logic w_hit;
	logic do_write;
	logic [2:0] wr_dec;
	logic [31:0] wr_mask;
	logic [ADDR_W-1:0] cur_addr;

	// Address and data are taken in either order; write fires once both are in
	always_comb
	begin
		s_axi_awready = (wr_state_r == WR_IDLE) && !aw_have_r;
		s_axi_wready = (wr_state_r == WR_IDLE) && !w_have_r;
		aw_hit = s_axi_awvalid && s_axi_awready;
		w_hit = s_axi_wvalid && s_axi_wready;
		cur_addr = aw_hit ? s_axi_awaddr : awaddr_r;
		wdata_nxt = w_hit ? s_axi_wdata : wdata_r;
		wstrb_nxt = w_hit ? s_axi_wstrb : wstrb_r;
		awaddr_nxt = cur_addr;
		wr_dec = decode_addr(cur_addr);
		wr_mask = wdata_nxt & strb_mask(wstrb_nxt);
		do_write = (wr_state_r == WR_IDLE) && (aw_have_r || aw_hit)
			&& (w_have_r || w_hit);
		aw_have_nxt = aw_have_r || aw_hit;
		w_have_nxt = w_have_r || w_hit;
		wr_state_nxt = wr_state_r;
		bresp_nxt = bresp_r;
		ctrl_nxt = ctrl_r;
		case (wr_state_r)
			WR_IDLE:
			begin
				if (do_write)
				begin
					aw_have_nxt = 1'b0;
					w_have_nxt = 1'b0;
					wr_state_nxt = WR_RESP;
					if (wr_dec[2])
					begin
						// Whole word is recomputed; untouched fields hold
						ctrl_nxt = apply_op(wr_dec[1:0], ctrl_r, wr_mask, wstrb_nxt);
						bresp_nxt = ref_ladder_pkg::RESP_OKAY;
					end
					else
						bresp_nxt = ref_ladder_pkg::RESP_DECERR;
				end
			end
			WR_RESP:
			begin
				if (s_axi_bready)
					wr_state_nxt = WR_IDLE;
			end
			default:
				wr_state_nxt = WR_IDLE;
		endcase
	end

	// Write state registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state_r <= WR_IDLE;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bresp_r <= ref_ladder_pkg::RESP_OKAY;
			ctrl_r <= ref_ladder_pkg::CTRL_RESET;
		end
		else
		begin
			wr_state_r <= wr_state_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bresp_r <= bresp_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	assign s_axi_bvalid = (wr_state_r == WR_RESP);
	assign s_axi_bresp = bresp_r;

	// ==========================================================
	// Read channel
	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} rd_state_e;

	rd_state_e rd_state_r;
	rd_state_e rd_state_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_r;
	logic [1:0] rresp_nxt;
	logic [2:0] rd_dec;

	// Unused bits are never stored, so masking here is a second guard
	always_comb
	begin
		s_axi_arready = (rd_state_r == RD_IDLE);
		rd_dec = decode_addr(s_axi_araddr);
		rd_state_nxt = rd_state_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		case (rd_state_r)
			RD_IDLE:
			begin
				if (s_axi_arvalid)
				begin
					rd_state_nxt = RD_RESP;
					if (rd_dec[2])
					begin
						rdata_nxt = ctrl_r & ref_ladder_pkg::CTRL_IMPL_MASK;
						rresp_nxt = ref_ladder_pkg::RESP_OKAY;
					end
					else
					begin
						rdata_nxt = 32'h0000_0000;
						rresp_nxt = ref_ladder_pkg::RESP_DECERR;
					end
				end
			end
			RD_RESP:
			begin
				if (s_axi_rready)
					rd_state_nxt = RD_IDLE;
			end
			default:
				rd_state_nxt = RD_IDLE;
		endcase
	end

	// Read state registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state_r <= RD_IDLE;
			rdata_r <= 32'h0000_0000;
			rresp_r <= ref_ladder_pkg::RESP_OKAY;
		end
		else
		begin
			rd_state_r <= rd_state_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign s_axi_rvalid = (rd_state_r == RD_RESP);
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ==========================================================
	// Ladder outputs
	assign ref_enable = ctrl_r[ref_ladder_pkg::EN_BIT];
	assign ref_pin_output_enable = ctrl_r[ref_ladder_pkg::OE_BIT];
	assign ref_range_select = ctrl_r[ref_ladder_pkg::RANGE_BIT];
	assign ref_source_select = ctrl_r[ref_ladder_pkg::SRC_BIT];
	assign ref_tap_code = ctrl_r[ref_ladder_pkg::TAP_LSB +: ref_ladder_pkg::TAP_W];

	ladder_level_calc u_calc
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(ref_enable),
		.pin_oe(ref_pin_output_enable),
		.range_hi(ref_range_select),
		.tap(ref_tap_code),
		.level_96ths(ref_level_96ths),
		.pin_connect(ref_output_pin_connect)
	);

	// ==========================================================
	// Assertions
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic wr_base;
	assign wr_base = do_write && wr_dec[2] && (wr_dec[1:0] == ref_ladder_pkg::OP_WRITE);
	chk_enable_write: assert property (
		wr_base && wstrb_nxt[1] |=> ref_enable == $past(wdata_nxt[15]))
		else $error("enable bit did not follow write");
	chk_enable_only: assert property (
		do_write && wr_dec[2] && wr_dec[1:0] != ref_ladder_pkg::OP_WRITE
		&& wr_mask == 32'h0000_8000 |=> ctrl_r[6:0] == $past(ctrl_r[6:0]))
		else $error("enable change disturbed other fields");
	chk_read_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[14:7] == 8'h00)
		else $error("unimplemented bits read nonzero");
	chk_src_read: assert property (
		s_axi_arvalid && s_axi_arready && rd_dec[2] && !do_write
		|=> s_axi_rdata[4] == ref_source_select)
		else $error("source select readback mismatch");
	chk_set_alias: assert property (
		do_write && wr_dec == 3'b110 |=> ctrl_r == (($past(ctrl_r)
		| $past(wr_mask)) & 32'h0000_807f))
		else $error("set alias wrong");
	chk_inv_alias: assert property (
		do_write && wr_dec == 3'b111 |=> ctrl_r == (($past(ctrl_r)
		^ $past(wr_mask)) & 32'h0000_807f))
		else $error("invert alias wrong");
	chk_clr_alias: assert property (
		do_write && wr_dec == 3'b101 |=> ctrl_r == ($past(ctrl_r) & ~$past(wr_mask)))
		else $error("clear alias wrong");
	chk_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");

endmodule : reference_ladder_control
